// ---- rtsr_regs.sv ----
// Reference trim word, user scratch word, range clamp and reference slew
`timescale 1ns/1ps
// ************************************************************
// ************************************************************
module rtsr_regs (
  input wire logic sys_clk,
  input wire logic reset,
  input wire rtsr_pkg::rtsr_cmd_t cmdIn,
  output rtsr_pkg::rtsr_rsp_t rspOut,
  input wire logic storeAll,
  output rtsr_pkg::rtsr_nvm_t nvmOut,
  input wire logic signed [15:0] marginStep,
  input wire logic softStartBusy,
  input wire logic [rtsr_pkg::DIV_W-1:0] riseStepCycles,
  input wire logic clearFaults,
  output rtsr_pkg::rtsr_status_t statusOut,
  output logic signed [15:0] targetOffset,
  output logic signed [15:0] refOffset,
  output logic [15:0] refSteps
);

  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RAMP = 2'b10
  } rtsr_slew_t;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic signed [17:0] clampSteps(
    input logic signed [17:0] val,
    input logic signed [17:0] lo,
    input logic signed [17:0] hi
  );
    if (val < lo) begin
      return lo;
    end else if (val > hi) begin
      return hi;
    end
    return val;
  endfunction

  function automatic logic isWrite(
    input rtsr_pkg::rtsr_cmd_t c,
    input logic [7:0] code
  );
    return c.valid && c.write && (c.code == code);
  endfunction

  localparam logic signed [17:0] TRIM_LO = 18'(rtsr_pkg::TRIM_MIN_STEPS);
  localparam logic signed [17:0] TRIM_HI = 18'(rtsr_pkg::TRIM_MAX_STEPS);
  localparam logic signed [17:0] SUM_LO = 18'(rtsr_pkg::SUM_MIN_STEPS);
  localparam logic signed [17:0] SUM_HI = 18'(rtsr_pkg::SUM_MAX_STEPS);
  localparam logic [rtsr_pkg::DIV_W-1:0] SLOW_CYC = rtsr_pkg::SLOW_STEP_CYCLES[rtsr_pkg::DIV_W-1:0];
  localparam logic [15:0] NOM_STEPS = 16'(rtsr_pkg::REF_NOM_STEPS);

  logic [15:0] scratchFf;
  logic signed [15:0] trimFf;
  logic signed [15:0] marginPrevFf;
  logic trimWriteDlyFf;
  logic [rtsr_pkg::DIV_W-1:0] gapCntFf;
  logic signed [15:0] targetFf;
  logic signed [15:0] refNowFf;
  logic [rtsr_pkg::DIV_W-1:0] divCntFf;
  rtsr_slew_t slewFf;
  rtsr_pkg::rtsr_rsp_t rspFf;
  rtsr_pkg::rtsr_nvm_t nvmFf;
  rtsr_pkg::rtsr_status_t statusFf;

  logic signed [17:0] trimClamped;
  logic signed [17:0] sumRaw;
  logic signed [17:0] sumClamped;
  logic trimBad;
  logic sumBad;
  logic rangeEvent;
  logic trimWrite;
  logic [rtsr_pkg::DIV_W-1:0] stepLimit;
  logic stepNow;

  // ************************************************************
  // Command port
  // ************************************************************
  assign trimWrite = isWrite(cmdIn, rtsr_pkg::CMD_TRIM);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scratchFf <= rtsr_pkg::SCRATCH_RST;
    end else if (isWrite(cmdIn, rtsr_pkg::CMD_SCRATCH)) begin
      scratchFf <= cmdIn.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trimFf <= rtsr_pkg::TRIM_RST;
    end else if (trimWrite) begin
      // Raw word kept so software reads back what it wrote
      trimFf <= cmdIn.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rspFf <= '0;
    end else begin
      rspFf.valid <= cmdIn.valid;
      rspFf.ack <= cmdIn.valid &&
        (cmdIn.code == rtsr_pkg::CMD_SCRATCH || cmdIn.code == rtsr_pkg::CMD_TRIM);
      if (cmdIn.valid && !cmdIn.write && cmdIn.code == rtsr_pkg::CMD_SCRATCH) begin
        rspFf.rdata <= scratchFf;
      end else if (cmdIn.valid && !cmdIn.write && cmdIn.code == rtsr_pkg::CMD_TRIM) begin
        rspFf.rdata <= trimFf;
      end else begin
        rspFf.rdata <= 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nvmFf <= '0;
    end else begin
      nvmFf.strobe <= storeAll;
      if (storeAll) begin
        nvmFf.scratch <= scratchFf;
        nvmFf.trim <= trimFf;
      end
    end
  end

  // ************************************************************
  // Range check and clamp
  // ************************************************************
  assign trimClamped = clampSteps(18'(trimFf), TRIM_LO, TRIM_HI);
  assign trimBad = (18'(trimFf) != trimClamped);
  assign sumRaw = trimClamped + 18'(marginStep);
  assign sumClamped = clampSteps(sumRaw, SUM_LO, SUM_HI);
  assign sumBad = (sumRaw != sumClamped);
  // Report once per new setting, not every cycle the setting stays bad
  assign rangeEvent = (trimBad || sumBad) && (trimWriteDlyFf || marginStep != marginPrevFf);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trimWriteDlyFf <= 1'b0;
      marginPrevFf <= 16'sh0000;
      targetFf <= 16'sh0000;
    end else begin
      trimWriteDlyFf <= trimWrite;
      marginPrevFf <= marginStep;
      targetFf <= sumClamped[15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      statusFf <= '0;
    end else if (rangeEvent) begin
      // Set beats a clear arriving in the same cycle
      statusFf <= '{alert: 1'b1, cml: 1'b1, invalidData: 1'b1};
    end else if (clearFaults) begin
      statusFf <= '0;
    end
  end

  // ************************************************************
  // Reference slew
  // ************************************************************
  assign stepLimit = softStartBusy ? riseStepCycles : SLOW_CYC;
  assign stepNow = (slewFf == ST_RAMP) && (divCntFf >= stepLimit - 1'b1);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      slewFf <= ST_HOLD;
      divCntFf <= '0;
    end else begin
      unique case (slewFf)
        ST_HOLD: begin
          divCntFf <= '0;
          if (targetFf != refNowFf) begin
            slewFf <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          // Target moved back onto the reference mid-ramp: nothing left to do
          if (targetFf == refNowFf) begin
            slewFf <= ST_HOLD;
          end else if (stepNow) begin
            divCntFf <= '0;
            if (refNowFf + (targetFf > refNowFf ? 16'sd1 : -16'sd1) == targetFf) begin
              slewFf <= ST_HOLD;
            end
          end else begin
            divCntFf <= divCntFf + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      refNowFf <= 16'sh0000;
    end else if (stepNow && targetFf > refNowFf) begin
      refNowFf <= refNowFf + 16'sd1;
    end else if (stepNow && targetFf < refNowFf) begin
      refNowFf <= refNowFf - 16'sd1;
    end
  end

  // Cycles since the last step; only the slow-slew check reads it
  always_ff @(posedge sys_clk) begin
    if (reset || stepNow) begin
      gapCntFf <= '0;
    end else if (gapCntFf != '1) begin
      gapCntFf <= gapCntFf + 1'b1;
    end
  end

  assign rspOut = rspFf;
  assign nvmOut = nvmFf;
  assign statusOut = statusFf;
  assign targetOffset = targetFf;
  assign refOffset = refNowFf;

  logic [15:0] refStepsFf;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      refStepsFf <= NOM_STEPS;
    end else begin
      refStepsFf <= NOM_STEPS + 16'(refNowFf);
    end
  end
  assign refSteps = refStepsFf;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_scratch_reset: assert property (@(posedge sys_clk) reset |=> scratchFf == 16'h0000)
    else $error("scratch not zero after reset");

  a_scratch_write: assert property (@(posedge sys_clk) disable iff (reset)
    isWrite(cmdIn, rtsr_pkg::CMD_SCRATCH) |=> scratchFf == $past(cmdIn.wdata))
    else $error("scratch write lost");

  a_trim_reset: assert property (@(posedge sys_clk) reset |=> trimFf == 16'sh0000)
    else $error("trim not zero after reset");

  a_trim_write: assert property (@(posedge sys_clk) disable iff (reset)
    trimWrite |=> trimFf == $past(cmdIn.wdata))
    else $error("trim write lost");

  a_known_ack: assert property (@(posedge sys_clk) disable iff (reset)
    (cmdIn.valid && (cmdIn.code == rtsr_pkg::CMD_SCRATCH || cmdIn.code == rtsr_pkg::CMD_TRIM))
    |=> rspFf.valid && rspFf.ack)
    else $error("known command not acknowledged");

  a_nvm_copy: assert property (@(posedge sys_clk) disable iff (reset)
    storeAll |=> nvmFf.strobe && nvmFf.trim == $past(trimFf)
      && nvmFf.scratch == $past(scratchFf))
    else $error("store did not copy words");

  a_target_bounds: assert property (@(posedge sys_clk) disable iff (reset)
    18'(targetFf) >= SUM_LO && 18'(targetFf) <= SUM_HI)
    else $error("target outside net range");

  a_sum_floor: assert property (@(posedge sys_clk) disable iff (reset)
    sumRaw < SUM_LO |=> 18'(targetFf) == SUM_LO)
    else $error("net offset not clamped low");

  a_trim_saturate: assert property (@(posedge sys_clk) disable iff (reset)
    (trimFf > 16'sd30 && marginStep == 16'sh0000) |=> targetFf == 16'sd30)
    else $error("high trim not saturated");

  a_trim_floor: assert property (@(posedge sys_clk) disable iff (reset)
    (18'(trimFf) < TRIM_LO && marginStep == 16'sh0000) |=> 18'(targetFf) == TRIM_LO)
    else $error("low trim not saturated");

  a_fault_flags: assert property (@(posedge sys_clk) disable iff (reset)
    trimWrite && (cmdIn.wdata[15] ? 16'(cmdIn.wdata) < 16'hFFC4 : cmdIn.wdata > 16'h001E)
      && marginStep == $past(marginStep)
    |=> ##1 statusFf.alert && statusFf.cml && statusFf.invalidData)
    else $error("out of range trim not reported");

  a_event_sets: assert property (@(posedge sys_clk) disable iff (reset)
    rangeEvent |=> statusFf.alert && statusFf.cml && statusFf.invalidData)
    else $error("range fault not flagged");

  a_slew_single: assert property (@(posedge sys_clk) disable iff (reset)
    refNowFf != $past(refNowFf) |-> (refNowFf - $past(refNowFf) == 16'sd1
      || $past(refNowFf) - refNowFf == 16'sd1))
    else $error("reference jumped");

  a_slow_gap: assert property (@(posedge sys_clk) disable iff (reset)
    (!softStartBusy && stepNow) |-> gapCntFf >= SLOW_CYC - 1'b1)
    else $error("slow slew stepped too fast");

endmodule // rtsr_regs

// ---- rtsr_pkg.sv ----
// Constants and carrier types for the reference trim and scratch register block
package rtsr_pkg;

  // ************************************************************
  // Command codes and reset values
  // ************************************************************
  localparam logic [7:0] CMD_SCRATCH = 8'hD0;
  localparam logic [7:0] CMD_TRIM = 8'hD4;
  localparam logic [15:0] SCRATCH_RST = 16'h0000;
  localparam logic [15:0] TRIM_RST = 16'h0000;
  localparam int WORD_W = 16;

  // ************************************************************
  // Reference scaling, all offsets counted in 2 mV steps
  // ************************************************************
  localparam int STEP_UV = 2000;
  localparam int REF_NOM_MV = 600;
  localparam int REF_NOM_STEPS = REF_NOM_MV * 1000 / STEP_UV;
  localparam int TRIM_MIN_MV = -120;
  localparam int TRIM_MAX_MV = 60;
  localparam int SUM_MIN_MV = -180;
  localparam int SUM_MAX_MV = 60;
  localparam int TRIM_MIN_STEPS = TRIM_MIN_MV * 1000 / STEP_UV;
  localparam int TRIM_MAX_STEPS = TRIM_MAX_MV * 1000 / STEP_UV;
  localparam int SUM_MIN_STEPS = SUM_MIN_MV * 1000 / STEP_UV;
  localparam int SUM_MAX_STEPS = SUM_MAX_MV * 1000 / STEP_UV;

  // ************************************************************
  // Slew timing: slowest rate 0.067 mV/us held as uV per us
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int SLOW_SLEW_UV_PER_US = 67;
  // Least time per step, rounded up to whole cycles
  localparam int SLOW_STEP_CYCLES =
    (STEP_UV * CLK_MHZ + SLOW_SLEW_UV_PER_US - 1) / SLOW_SLEW_UV_PER_US;
  localparam int DIV_W = 16;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } rtsr_cmd_t;

  typedef struct packed {
    logic valid;
    logic ack;
    logic [15:0] rdata;
  } rtsr_rsp_t;

  typedef struct packed {
    logic strobe;
    logic [15:0] scratch;
    logic [15:0] trim;
  } rtsr_nvm_t;

  typedef struct packed {
    logic alert;
    logic cml;
    logic invalidData;
  } rtsr_status_t;

endpackage

// ---- rtsr_host_model.sv ----
// Host model that issues command-port reads and writes
`timescale 1ns/1ps
module rtsr_host_model (
  input wire logic sys_clk,
  output rtsr_pkg::rtsr_cmd_t cmdIn,
  input wire rtsr_pkg::rtsr_rsp_t rspOut
);
  initial cmdIn = '0;
  // Request is a one-edge pulse; idle fields show inverted values so stale data cannot pass
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
                        output logic ack, output logic [15:0] rdata);
    int n;
    ack = 1'b0;
    rdata = 16'hDEAD;
    @(posedge sys_clk);
    cmdIn <= '{valid: 1'b1, write: wr, code: code, wdata: wdata};
    @(posedge sys_clk);
    cmdIn <= '{valid: 1'b0, write: ~wr, code: ~code, wdata: ~wdata};
    for (n = 0; n < 4; n++) begin
      @(posedge sys_clk);
      if (rspOut.valid === 1'b1) begin
        ack = rspOut.ack;
        rdata = rspOut.rdata;
        break;
      end
    end
  endtask
endmodule // rtsr_host_model

// ---- reference_trim_scratch_regs_tb.sv ----
// Self-checking testbench for the reference trim and scratch registers
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module reference_trim_scratch_regs_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic storeAll = 1'b0;
  logic clearFaults = 1'b0;
  logic softStartBusy = 1'b1;
  logic signed [15:0] marginStep = 16'h0000;
  logic [15:0] riseStepCycles = 16'h0002;
  rtsr_pkg::rtsr_cmd_t cmdIn;
  rtsr_pkg::rtsr_rsp_t rspOut;
  rtsr_pkg::rtsr_nvm_t nvmOut;
  rtsr_pkg::rtsr_status_t statusOut;
  logic signed [15:0] targetOffset;
  logic signed [15:0] refOffset;
  logic [15:0] refSteps;
  int compares = 0;
  int miscompares = 0;
  int cycles = 0;
  logic [15:0] badTrim [2] = '{16'h001F, 16'hFFC3};
  logic [15:0] clampTrim [2] = '{16'h001E, 16'hFFC4};

  always #4 sys_clk = ~sys_clk;

  rtsr_regs dut (.sys_clk(sys_clk), .reset(reset), .cmdIn(cmdIn), .rspOut(rspOut),
    .storeAll(storeAll), .nvmOut(nvmOut), .marginStep(marginStep),
    .softStartBusy(softStartBusy), .riseStepCycles(riseStepCycles),
    .clearFaults(clearFaults), .statusOut(statusOut), .targetOffset(targetOffset),
    .refOffset(refOffset), .refSteps(refSteps));
  rtsr_host_model host (.sys_clk(sys_clk), .cmdIn(cmdIn), .rspOut(rspOut));

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic expAck);
    logic a;
    logic [15:0] r;
    host.access(1'b1, c, d, a, r);
    `CHK(a, expAck)
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic a;
    logic [15:0] r;
    host.access(1'b0, c, 16'h0000, a, r);
    `CHK(a, 1'b1)
    `CHK(r, e)
  endtask

  task automatic pulse_clear();
    @(posedge sys_clk) clearFaults <= 1'b1;
    @(posedge sys_clk) clearFaults <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK(statusOut, 3'h0)
  endtask

  task automatic print_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Ceiling sits well above the longest path, dominated by the slow slew
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    rd(rtsr_pkg::CMD_SCRATCH, 16'h0000);
    rd(rtsr_pkg::CMD_TRIM, 16'h0000);
    `CHK(refSteps, 16'h012C)
    $display("test reset done");
    wr(rtsr_pkg::CMD_SCRATCH, 16'hA5C3, 1'b1);
    wr(8'hD1, 16'hFFFF, 1'b0);
    rd(rtsr_pkg::CMD_SCRATCH, 16'hA5C3);
    `CHK(targetOffset, 16'h0000)
    $display("test scratch done");
    wr(rtsr_pkg::CMD_TRIM, 16'hFFF6, 1'b1);
    rd(rtsr_pkg::CMD_TRIM, 16'hFFF6);
    repeat (250) @(posedge sys_clk);
    `CHK(targetOffset, 16'hFFF6)
    `CHK(refSteps, 16'h0122)
    `CHK(statusOut, 3'h0)
    $display("test trim done");
    @(posedge sys_clk) storeAll <= 1'b1;
    @(posedge sys_clk) storeAll <= 1'b0;
    @(posedge sys_clk);
    `CHK(nvmOut, 33'h1A5C3FFF6)
    $display("test store done");
    for (int i = 0; i < 2; i++) begin
      wr(rtsr_pkg::CMD_TRIM, badTrim[i], 1'b1);
      repeat (4) @(posedge sys_clk);
      `CHK(targetOffset, clampTrim[i])
      `CHK(statusOut, 3'h7)
      pulse_clear();
    end
    $display("test range done");
    @(posedge sys_clk) marginStep <= 16'hFFD8;
    repeat (4) @(posedge sys_clk);
    `CHK(targetOffset, 16'hFFA6)
    `CHK(statusOut, 3'h7)
    @(posedge sys_clk) marginStep <= 16'h0000;
    repeat (250) @(posedge sys_clk);
    pulse_clear();
    `CHK(refOffset, 16'hFFC4)
    `CHK(refSteps, 16'h00F0)
    $display("test sum done");
    @(posedge sys_clk) softStartBusy <= 1'b0;
    wr(rtsr_pkg::CMD_TRIM, 16'hFFC6, 1'b1);
    // One step per slow period: start value, then a single step, then the end value
    repeat (3700) @(posedge sys_clk);
    `CHK(refOffset, 16'hFFC4)
    repeat (100) @(posedge sys_clk);
    `CHK(refOffset, 16'hFFC5)
    repeat (3900) @(posedge sys_clk);
    `CHK(refOffset, 16'hFFC6)
    `CHK(refSteps, 16'h00F2)
    $display("test slew done");
    print_verdict();
  end
endmodule // reference_trim_scratch_regs_tb
